// ---- adc_serial_readout.v ----
// Serial result readout and interface mode selection of a 16-bit converter.
// Assumes start, serial input and serial clock pins arrive asynchronously;
// the result code comes from the converter core on the same clock.
`timescale 1ns/100ps
`include "adc_readout_defines.vh"

module adc_serial_readout
(
    // Clock and reset
    input  wire                clock,
    input  wire                rst_n,
    // Converter core
    input  wire [`WORD_W-1:0]  resultCode,
    // Pins from the host
    input  wire                convStartPin,
    input  wire                serialInPin,
    input  wire                serialClkPin,
    // Serial output pin
    output reg                 serialOutPin,
    output reg                 serialOutEn,
    // Status
    output reg                 convActive,
    output reg                 chainMode
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg  [1:0] startSync_q;
    reg  [1:0] sdiSync_q;
    reg  [1:0] sclkSync_q;
    reg        startPrev_q;
    reg        sclkPrev_q;
    reg        csPrev_q;

    wire startLvl  = startSync_q[1];
    wire sdiLvl    = sdiSync_q[1];
    wire sclkLvl   = sclkSync_q[1];
    wire startRise = startLvl & ~startPrev_q;
    wire sclkFall  = ~sclkLvl & sclkPrev_q;
    // Select is active low on either wiring: start in three-wire, input in four
    wire csN       = startLvl & sdiLvl;
    wire csFall    = ~csN & csPrev_q;

    // Two flops per pin, then edge history on the second stage
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            startSync_q <= 2'h0;
            sdiSync_q   <= 2'h0;
            sclkSync_q  <= 2'h0;
            startPrev_q <= 1'h0;
            sclkPrev_q  <= 1'h0;
            csPrev_q    <= 1'h0; // Same as csN after reset, no false fall
        end
        else
        begin
            startSync_q <= {startSync_q[0], convStartPin};
            sdiSync_q   <= {sdiSync_q[0], serialInPin};
            sclkSync_q  <= {sclkSync_q[0], serialClkPin};
            startPrev_q <= startLvl;
            sclkPrev_q  <= sclkLvl;
            csPrev_q    <= csN;
        end
    end

    // ------------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------------
    reg  [1:0]             convState_q;
    reg  [`CONV_CNT_W-1:0] convCnt_q;
    reg  [`WORD_W-1:0]     sampleHold_q;
    wire                   convIdle = (convState_q == `ST_IDLE);
    wire                   fifoInReady;
    wire                   fifoInValid = (convState_q == `ST_STORE);
    wire                   startEvt = startRise & convIdle;

    // Start edge samples the code; fixed count ends it; full buffer stalls
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            convState_q  <= `ST_IDLE;
            convCnt_q    <= {`CONV_CNT_W{1'b0}};
            sampleHold_q <= {`WORD_W{1'b0}};
            convActive   <= 1'h0;
        end
        else
        begin
            case (convState_q)
                `ST_IDLE:
                begin
                    if (startRise)
                    begin
                        sampleHold_q <= resultCode;
                        convCnt_q    <= {`CONV_CNT_W{1'b0}};
                        convState_q  <= `ST_CONV;
                        convActive   <= 1'h1;
                    end
                end
                `ST_CONV:
                begin
                    // Pins are not looked at while counting
                    if (convCnt_q == `CONV_CYCLES - 1)
                        convState_q <= `ST_STORE;
                    else
                        convCnt_q <= convCnt_q + 1'b1;
                end
                `ST_STORE:
                begin
                    if (fifoInReady)
                    begin
                        convState_q <= `ST_IDLE;
                        convActive  <= 1'h0;
                    end
                end
                default:
                begin
                    convState_q <= `ST_IDLE;
                    convActive  <= 1'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------------
    wire               fifoOutValid;
    wire [`WORD_W-1:0] fifoOutData;
    reg                live_q;
    wire               loadReady = ~live_q;
    wire               endEvt    = fifoOutValid & loadReady;

    sample_fifo
    #(
        .WIDTH  (`WORD_W),
        .DEPTH  (`FIFO_DEPTH),
        .ADDR_W (`FIFO_ADDR_W)
    )
    resultBuf
    (
        .clock    (clock),
        .rst_n    (rst_n),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (sampleHold_q),
        .outValid (fifoOutValid),
        .outReady (loadReady),
        .outData  (fifoOutData)
    );

    // ------------------------------------------------------------------
    // Readout shifter
    // ------------------------------------------------------------------
    reg  [`WORD_W-1:0]    shift_q;
    reg  [`FALL_CNT_W-1:0] fallCnt_q;
    reg                   busyMode_q;
    reg                   busyPend_q;
    reg                   armed_q;
    wire [`FALL_CNT_W-1:0] fallNext = fallCnt_q + 1'b1;

    // Number of clock falls after which the output floats
    function [`FALL_CNT_W-1:0] fallLimit;
        input busy;
        begin
            fallLimit = busy ? `FALLS_BUSY : `FALLS_PLAIN;
        end
    endfunction

    // Mode pick, word load, and the per-fall shifting
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            shift_q      <= {`WORD_W{1'b0}};
            fallCnt_q    <= {`FALL_CNT_W{1'b0}};
            busyMode_q   <= 1'h0;
            busyPend_q   <= 1'h0;
            armed_q      <= 1'h0;
            live_q       <= 1'h0;
            chainMode    <= 1'h0;
            serialOutPin <= 1'h0;
            serialOutEn  <= 1'h0;
        end
        else if (startEvt)
        begin
            chainMode  <= ~sdiLvl;
            busyMode_q <= sclkLvl;
            live_q     <= 1'h0;
            armed_q    <= 1'h0;
            busyPend_q <= 1'h0;
            // Chain drives low at once; select modes float
            serialOutPin <= 1'h0;
            serialOutEn  <= ~sdiLvl;
        end
        else if (endEvt)
        begin
            shift_q   <= fifoOutData;
            fallCnt_q <= {`FALL_CNT_W{1'b0}};
            if (chainMode)
            begin
                live_q       <= 1'h1;
                busyPend_q   <= busyMode_q;
                serialOutEn  <= 1'h1;
                serialOutPin <= busyMode_q ? `BUSY_BIT_LEVEL
                                           : fifoOutData[`WORD_W-1];
            end
            else if (~csN)
            begin
                // Select still low at the end asks for the busy bit
                busyMode_q   <= 1'h1;
                busyPend_q   <= 1'h1;
                live_q       <= 1'h1;
                serialOutEn  <= 1'h1;
                serialOutPin <= `BUSY_BIT_LEVEL;
            end
            else
            begin
                busyMode_q <= 1'h0;
                armed_q    <= 1'h1;
            end
        end
        else if (chainMode)
        begin
            if (live_q & sclkFall)
            begin
                if (busyPend_q)
                begin
                    busyPend_q   <= 1'h0;
                    serialOutPin <= shift_q[`WORD_W-1];
                end
                else
                begin
                    // Upstream bit enters as ours leaves
                    shift_q      <= {shift_q[`WORD_W-2:0], sdiLvl};
                    serialOutPin <= shift_q[`WORD_W-2];
                end
            end
        end
        else if (armed_q & csFall)
        begin
            armed_q      <= 1'h0;
            live_q       <= 1'h1;
            serialOutEn  <= 1'h1;
            serialOutPin <= shift_q[`WORD_W-1];
        end
        else if (live_q & csN)
        begin
            live_q      <= 1'h0;
            serialOutEn <= 1'h0;
        end
        else if (live_q & sclkFall)
        begin
            fallCnt_q <= fallNext;
            if (fallNext == fallLimit(busyMode_q))
            begin
                live_q      <= 1'h0;
                serialOutEn <= 1'h0;
            end
            else if (busyPend_q)
            begin
                busyPend_q   <= 1'h0;
                serialOutPin <= shift_q[`WORD_W-1];
            end
            else
            begin
                shift_q      <= {shift_q[`WORD_W-2:0], 1'b0};
                serialOutPin <= shift_q[`WORD_W-2];
            end
        end
    end

endmodule

// ---- adc_readout_defines.vh ----
// Constants for the serial readout and mode selection of the converter.
// Assumes a 20 MHz system clock; the conversion count is in cycles of that clock, readout counts in serial clock falls.
`ifndef ADC_READOUT_DEFINES_VH
`define ADC_READOUT_DEFINES_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   50
`define CONV_TIME_NS    1400
`define CONV_CYCLES     ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W      6

// ----------------------------------------------------------------------
// Data word and readout counts
// ----------------------------------------------------------------------
`define WORD_W          16
`define FALLS_PLAIN     5'h10
`define FALLS_BUSY      5'h11
`define FALL_CNT_W      5
`define BUSY_BIT_LEVEL  1'h0
`define FIFO_DEPTH      16
`define FIFO_ADDR_W     4

// ----------------------------------------------------------------------
// Conversion state codes
// ----------------------------------------------------------------------
`define ST_IDLE         2'h0
`define ST_CONV         2'h1
`define ST_STORE        2'h2

`endif

// ---- sample_fifo.v ----
// Small first-in first-out buffer for conversion results.
// Assumes one clock; pushes and pops are valid/ready handshakes.
`timescale 1ns/100ps

module sample_fifo
#(
    parameter WIDTH  = 16,
    parameter DEPTH  = 16,
    parameter ADDR_W = 4
)
(
    // Clock and reset
    input  wire              clock,
    input  wire              rst_n,
    // Filling side
    input  wire              inValid,
    output wire              inReady,
    input  wire [WIDTH-1:0]  inData,
    // Draining side
    output wire              outValid,
    input  wire              outReady,
    output wire [WIDTH-1:0]  outData
);

    reg  [WIDTH-1:0]  mem [0:DEPTH-1];
    reg  [ADDR_W-1:0] wrPtr_q;
    reg  [ADDR_W-1:0] rdPtr_q;
    reg  [ADDR_W:0]   count_q;
    reg  [WIDTH-1:0]  outData_q;
    wire              doPush;
    wire              doPop;
    wire [ADDR_W-1:0] rdNext;

    // Handshake terms; full and empty come from the fill count
    assign inReady  = (count_q != DEPTH[ADDR_W:0]);
    assign outValid = (count_q != {(ADDR_W+1){1'b0}});
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;
    assign rdNext   = doPop ? rdPtr_q + 1'b1 : rdPtr_q;
    assign outData  = outData_q;

    // Storage write
    always @(posedge clock)
    begin
        if (doPush)
            mem[wrPtr_q] <= inData;
    end

    // Head word register; a push into the next head slot is forwarded
    always @(posedge clock)
    begin
        if (doPush && (wrPtr_q == rdNext))
            outData_q <= inData;
        else
            outData_q <= mem[rdNext];
    end

    // Pointers and fill count
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            wrPtr_q <= {ADDR_W{1'b0}};
            rdPtr_q <= {ADDR_W{1'b0}};
            count_q <= {(ADDR_W+1){1'b0}};
        end
        else
        begin
            if (doPush)
                wrPtr_q <= wrPtr_q + 1'b1;
            if (doPop)
                rdPtr_q <= rdPtr_q + 1'b1;
            if (doPush & ~doPop)
                count_q <= count_q + 1'b1;
            else if (doPop & ~doPush)
                count_q <= count_q - 1'b1;
        end
    end

endmodule

// ---- adc_readout_asserts.sv ----
// Checker for the serial readout pins of the converter.
// Assumes it is bound to adc_serial_readout and sees only its ports.
`timescale 1ns/100ps

module adc_readout_asserts
(
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Pins and status
    input wire convStartPin,
    input wire serialInPin,
    input wire serialClkPin,
    input wire serialOutPin,
    input wire serialOutEn,
    input wire convActive,
    input wire chainMode
);
    reg [5:0] convCnt_q;
    reg [4:0] clkHist_q;
    reg [3:0] actHist_q;

    // Conversion length and recent pin history
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            convCnt_q <= 6'h00;
            clkHist_q <= 5'h00;
            actHist_q <= 4'h0;
        end
        else
        begin
            convCnt_q <= !convActive ? 6'h00 :
                         convCnt_q + {5'h00, convCnt_q != 6'h3F};
            clkHist_q <= {clkHist_q[3:0], serialClkPin};
            actHist_q <= {actHist_q[2:0], convActive};
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    // Select held high in chip-select mode
    sequence deselHeld;
        (!chainMode && convStartPin && serialInPin) [*5];
    endsequence

    // Driving, no conversion lately, serial clock high long enough
    sequence clkQuiet;
        serialOutEn && $past(serialOutEn) && clkHist_q[4:1] == 4'hF &&
        actHist_q == 4'h0 && !convActive;
    endsequence

    conv_min_a: assert property ($fell(convActive) |-> convCnt_q >= 6'h1C)
        else $error("conversion ended early");
    conv_max_a: assert property ($rose(convActive) |-> ##[28:1000] !convActive)
        else $error("conversion never ended");
    cs_float_a: assert property (convActive && $past(convActive) && !chainMode
        |-> !serialOutEn) else $error("output driven during conversion");
    chain_drive_a: assert property ($rose(convActive) ##1 chainMode
        |-> serialOutEn && !serialOutPin) else $error("chain start not low");
    chain_hold_a: assert property (chainMode && $past(chainMode)
        |-> serialOutEn) else $error("chain output released");
    mode_pick_a: assert property ($rose(convActive)
        |=> chainMode != $past(serialInPin, 5)) else $error("wrong mode");
    sel_enable_a: assert property ($rose(serialOutEn) && !chainMode
        && !convActive |-> $past(!(convStartPin && serialInPin), 3))
        else $error("output enabled without select");
    desel_float_a: assert property (deselHeld |-> !serialOutEn)
        else $error("output driven while deselected");
    bit_steady_a: assert property (clkQuiet |-> $stable(serialOutPin))
        else $error("output changed without clock fall");
endmodule

bind adc_serial_readout adc_readout_asserts chk
(
    .clock        (clock),
    .rst_n        (rst_n),
    .convStartPin (convStartPin),
    .serialInPin  (serialInPin),
    .serialClkPin (serialClkPin),
    .serialOutPin (serialOutPin),
    .serialOutEn  (serialOutEn),
    .convActive   (convActive),
    .chainMode    (chainMode)
);

// ---- adc_host_model.sv ----
// Host model: drives start, select or chain data, and the serial clock.
// Assumes the bench calls its tasks; pins change at clock falling edges.
`timescale 1ns/100ps

module adc_host_model
(
    // Clock
    input wire clock,
    // Pins toward the converter
    output reg convStartPin,
    output reg serialInPin,
    output reg serialClkPin
);
    // Idle levels: start low, select high, serial clock low
    initial
    begin
        convStartPin = 1'h0;
        serialInPin  = 1'h1;
        serialClkPin = 1'h0;
    end

    // -----------------------------------------------------------------
    // Tasks; mode bit 2 chain, bit 1 four-wire, bit 0 busy bit
    // -----------------------------------------------------------------
    task tick(input integer n);
    begin
        repeat (n) @(negedge clock);
    end
    endtask

    // Start edge with mode and busy levels set up beforehand
    task start(input [2:0] m);
    begin
        convStartPin = 1'h0;
        serialInPin  = !m[2];
        serialClkPin = m[2] & m[0];
        tick(2);
        convStartPin = 1'h1;
        tick(5);
    end
    endtask

    // Pin activity allowed while converting
    task midconv(input [2:0] m);
    begin
        tick(3);
        if (m[2:1] == 2'h0)
            convStartPin = 1'h0;
        if (m == 3'h3)
            serialInPin = 1'h0;
        tick(4);
        if (m == 3'h0)
            convStartPin = 1'h1;
    end
    endtask

    // Select the device for a plain readout
    task select(input [2:0] m);
    begin
        if (m == 3'h0)
            convStartPin = 1'h0;
        if (m == 3'h2)
            serialInPin = 1'h0;
        tick(5);
    end
    endtask

    // One serial clock period of 400 ns, chain data set before the fall
    task fall(input ch, input b);
    begin
        if (ch)
            serialInPin = b;
        serialClkPin = 1'h1;
        tick(4);
        serialClkPin = 1'h0;
        tick(4);
    end
    endtask

    // Deselect, and end a chain readout
    task finish(input [2:0] m);
    begin
        serialInPin  = 1'h1;
        serialClkPin = 1'h0;
        if (m[2])
            convStartPin = 1'h0;
        tick(6);
    end
    endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the serial readout in all six modes.
// Assumes the host model drives the pins and the checker is bound.
`timescale 1ns/100ps

module tb;
    localparam [95:0] CORNERS = 96'h0000_8000_FFFF_7FFF_0001_FFFE;
    reg         clock;
    reg         rst_n;
    reg  [15:0] resultCode;
    reg  [31:0] seed;
    wire        convStartPin;
    wire        serialInPin;
    wire        serialClkPin;
    wire        serialOutPin;
    wire        serialOutEn;
    wire        convActive;
    wire        chainMode;
    integer     failures;
    integer     num_checks;
    integer     cycles;
    integer     p;
    integer     m;

    adc_serial_readout dut (.clock(clock), .rst_n(rst_n),
        .resultCode(resultCode), .convStartPin(convStartPin),
        .serialInPin(serialInPin), .serialClkPin(serialClkPin),
        .serialOutPin(serialOutPin), .serialOutEn(serialOutEn),
        .convActive(convActive), .chainMode(chainMode));
    adc_host_model host (.clock(clock), .convStartPin(convStartPin),
        .serialInPin(serialInPin), .serialClkPin(serialClkPin));

    // 20 MHz clock
    initial
    begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (cycles == 9000)
        begin
            failures = failures + 1;
            final_report;
        end
    end

    function [31:0] xs(input [31:0] s);
    begin
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    end
    endfunction

    task chk(input [63:0] what, input [15:0] exp, input [15:0] got);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("Error %0s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task final_report;
    begin
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    // One conversion and readout; cut ends a four-wire read early
    task run(input [2:0] md, input ps);
        reg [15:0] code;
        reg [15:0] up;
        reg [31:0] word;
        reg        busy;
        reg        ch;
        reg        cut;
        integer    i;
        integer    n;
    begin
        seed = xs(seed);
        code = ps ? seed[15:0] : CORNERS[95 - 16 * md -: 16];
        seed = xs(seed);
        up   = seed[15:0];
        busy = md[0];
        ch   = md[2];
        cut  = ps & md[1] & !ch;
        word = ch ? {code, up} : {code, 16'h0000};
        n    = ch ? 32 : (cut ? 8 : 16);
        resultCode = code;
        host.start(md);
        chk("mode", {15'h0, ch}, {15'h0, chainMode});
        chk("startEn", {15'h0, ch}, {15'h0, serialOutEn});
        if (ch)
            chk("startLow", 16'h0000, {15'h0, serialOutPin});
        seed = xs(seed);
        resultCode = seed[15:0];
        host.midconv(md);
        while (convActive !== 1'h0)
            host.tick(1);
        host.tick(3);
        host.select(md);
        chk("readEn", 16'h0001, {15'h0, serialOutEn});
        if (busy)
            chk("busyBit", 16'h0000, {15'h0, serialOutPin});
        for (i = 0; i < n; i = i + 1)
        begin
            if (i > 0 || busy)
                host.fall(ch, (i > 0 && i <= 16) ? up[16 - i] : 1'h0);
            chk("dataBit", {15'h0, word[31 - i]}, {15'h0, serialOutPin});
        end
        if (ch)
            chk("chainEn", 16'h0001, {15'h0, serialOutEn});
        else
        begin
            if (cut)
                host.finish(md);
            else
                host.fall(1'h0, 1'h0);
            host.tick(2);
            chk("float", 16'h0000, {15'h0, serialOutEn});
        end
        host.finish(md);
        $display("mode %0d pass %0d done", md, ps);
    end
    endtask

    // Reset, then every mode with corner codes and with random codes
    initial
    begin
        failures   = 0;
        num_checks = 0;
        cycles     = 0;
        seed       = 32'h0000_0005;
        rst_n      = 1'h0;
        resultCode = 16'h0000;
        repeat (4) @(negedge clock);
        rst_n = 1'h1;
        for (p = 0; p < 2; p = p + 1)
            for (m = 0; m < 6; m = m + 1)
                run(m[2:0], p[0]);
        final_report;
    end
endmodule
